// ---- hw/bmd_decode.sv ----
`timescale 1ns/1ns
module bmd_decode (
  bmd_file_if.decode dec
);
  always_comb begin
    dec.indirect = 1'b0;
    dec.file_addr = {bmd_pkg::bmd_bank(dec.status), dec.offset};
    if (dec.offset == bmd_pkg::IDX_INDIRECT) begin
      // One level only: a pointer aimed at 00h lands on nothing
      dec.indirect = 1'b1;
      dec.file_addr = {dec.status[bmd_pkg::IND_BANK_BIT], dec.pointer};
    end
    dec.target = bmd_pkg::bmd_classify(dec.file_addr);
    dec.ram_index = bmd_pkg::bmd_ram_index(dec.file_addr);
  end
endmodule : bmd_decode

// ---- hw/bmd_gpr_ram.sv ----
`timescale 1ns/1ns
module bmd_gpr_ram #(
  parameter int DEPTH = bmd_pkg::RAM_DEPTH
) (
  input wire logic clock,
  bmd_ram_if.store ram
);
  logic [7:0] mem [DEPTH];

  // Holes left by control registers and the aliased common areas are never written, leaving 144 of the 512 bytes unused
  always_ff @(posedge clock) begin
    if (ram.we) begin
      mem[ram.index] <= ram.wdata;
    end
  end

  assign ram.rdata = mem[ram.index];
endmodule : bmd_gpr_ram

// ---- hw/bmd_if.sv ----
`timescale 1ns/1ns
interface bmd_file_if;
  logic [7:0] status;
  logic [7:0] pointer;
  logic [6:0] offset;
  logic indirect;
  logic [8:0] file_addr;
  logic [8:0] ram_index;
  bmd_pkg::bmd_target_t target;
  modport decode (input status, input pointer, input offset,
                  output indirect, output file_addr, output ram_index, output target);
  modport user (output status, output pointer, output offset,
                input indirect, input file_addr, input ram_index, input target);
endinterface : bmd_file_if

interface bmd_ram_if;
  logic we;
  logic [8:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport owner (output we, output index, output wdata, input rdata);
  modport store (input we, input index, input wdata, output rdata);
endinterface : bmd_ram_if

// ---- hw/bmd_pkg.sv ----
// What this block does
// - Direct bank number comes from status bit 6 (high) and bit 5 (low); indirect uses status bit 7 and pointer bit 7.
// - Four banks: select 00 is bank 0, through 11 for bank 3.
// - Bank is 128 bytes, offsets 00h-7Fh, full address is bank then offset.
// - Lowest offsets of every bank decode to control registers; bank 0 uses 00h-1Fh.
// - Offsets above control registers are general RAM; bank 0 holds 96 bytes from 20h.
// - Every bank has a control register region at its low offsets.
// - Status and pointer registers answer at the same offset in all banks.
// - Any location is reachable directly or through the pointer register.
package bmd_pkg;
  localparam int FILE_AW = 9;
  localparam int OFS_W = 7;
  localparam int DATA_W = 8;
  localparam int RAM_DEPTH = 512;
  localparam int BANK_HI_BIT = 6;
  localparam int BANK_LO_BIT = 5;
  localparam int IND_BANK_BIT = 7;
  localparam int APB_IDX_LSB = 2;
  localparam int APB_IDX_MSB = 8;
  localparam logic [6:0] IDX_INDIRECT = 7'h00;
  localparam logic [6:0] IDX_STATUS = 7'h03;
  localparam logic [6:0] IDX_POINTER = 7'h04;
  localparam logic [6:0] SFR_TOP_LOW = 7'h1F;
  localparam logic [6:0] SFR_TOP_HIGH = 7'h0F;
  localparam logic [6:0] COMMON_BASE = 7'h70;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] POINTER_RST = 8'h00;

  typedef enum logic [3:0] {
    BMD_TGT_GPR = 4'h1,
    BMD_TGT_STATUS = 4'h2,
    BMD_TGT_POINTER = 4'h4,
    BMD_TGT_NONE = 4'h8
  } bmd_target_t;

  function automatic logic [1:0] bmd_bank(input logic [7:0] status);
    return {status[BANK_HI_BIT], status[BANK_LO_BIT]};
  endfunction : bmd_bank

  // Banks 2 and 3 give their upper control half to RAM
  function automatic bmd_target_t bmd_classify(input logic [8:0] addr);
    logic [6:0] top;
    top = (addr[8] == 1'b0) ? SFR_TOP_LOW : SFR_TOP_HIGH;
    if (addr[6:0] == IDX_STATUS) begin
      return BMD_TGT_STATUS;
    end else if (addr[6:0] == IDX_POINTER) begin
      return BMD_TGT_POINTER;
    end else if (addr[6:0] <= top) begin
      return BMD_TGT_NONE;
    end else begin
      return BMD_TGT_GPR;
    end
  endfunction : bmd_classify

  function automatic logic [8:0] bmd_ram_index(input logic [8:0] addr);
    if (addr[6:0] >= COMMON_BASE) begin
      return {2'b00, addr[6:0]};
    end else begin
      return addr;
    end
  endfunction : bmd_ram_index
endpackage : bmd_pkg

// ---- hw/bmd_top.sv ----
`timescale 1ns/1ns
module bmd_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bank_sel_high,
  output logic bank_sel_low
);
  logic [7:0] status_reg;
  logic [7:0] pointer_reg;
  logic [31:0] prdata_reg;
  logic addr_ok;
  logic setup_ph;
  logic access_ph;
  logic wr_fire;

  bmd_file_if dec_if ();
  bmd_ram_if ram_if ();

  bmd_decode u_decode (
    .dec(dec_if.decode)
  );

  bmd_gpr_ram #(
    .DEPTH(bmd_pkg::RAM_DEPTH)
  ) u_ram (
    .clock(clock),
    .ram(ram_if.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  assign addr_ok = (paddr[31:9] == 23'h000000) && (paddr[1:0] == 2'h0);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  // Only byte lane 0 carries data; other lanes are ignored
  assign wr_fire = access_ph && pwrite && addr_ok && pstrb[0];

  assign dec_if.status = status_reg;
  assign dec_if.pointer = pointer_reg;
  assign dec_if.offset = paddr[bmd_pkg::APB_IDX_MSB:bmd_pkg::APB_IDX_LSB];

  assign ram_if.we = wr_fire && (dec_if.target == bmd_pkg::BMD_TGT_GPR);
  assign ram_if.index = dec_if.ram_index;
  assign ram_if.wdata = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_ok;
  assign prdata = prdata_reg;
  assign bank_sel_high = status_reg[bmd_pkg::BANK_HI_BIT];
  assign bank_sel_low = status_reg[bmd_pkg::BANK_LO_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Mirrored control registers, same flops seen from every bank
  always_ff @(posedge clock) begin
    if (srst) begin
      status_reg <= bmd_pkg::STATUS_RST;
    end else if (wr_fire && dec_if.target == bmd_pkg::BMD_TGT_STATUS) begin
      status_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pointer_reg <= bmd_pkg::POINTER_RST;
    end else if (wr_fire && dec_if.target == bmd_pkg::BMD_TGT_POINTER) begin
      pointer_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in setup; status and pointer cannot move before access
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_reg <= 32'h00000000;
      if (addr_ok && !pwrite) begin
        case (dec_if.target)
          bmd_pkg::BMD_TGT_GPR: prdata_reg <= {24'h000000, ram_if.rdata};
          bmd_pkg::BMD_TGT_STATUS: prdata_reg <= {24'h000000, status_reg};
          bmd_pkg::BMD_TGT_POINTER: prdata_reg <= {24'h000000, pointer_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_BANK_FROM_STATUS: assert property (@(posedge clock) disable iff (srst)
    !dec_if.indirect |-> dec_if.file_addr[8:7] == {status_reg[6], status_reg[5]})
    else $error("direct bank differs from status bits");

  AST_BANK3_MAP: assert property (@(posedge clock) disable iff (srst)
    (status_reg[6:5] == 2'b11 && dec_if.offset == 7'h20) |-> dec_if.file_addr == 9'h1A0)
    else $error("bank 3 offset 20h not at 1A0h");

  AST_OFFSET_KEPT: assert property (@(posedge clock) disable iff (srst)
    !dec_if.indirect |-> dec_if.file_addr[6:0] == dec_if.offset)
    else $error("in-bank offset altered");

  AST_BANK0_SFR: assert property (@(posedge clock) disable iff (srst)
    // Offset 00h is left out: through the pointer it may legally land in RAM
    (status_reg[6:5] == 2'b00 && dec_if.offset != 7'h00 && dec_if.offset <= 7'h1F)
    |-> dec_if.target != bmd_pkg::BMD_TGT_GPR)
    else $error("bank 0 low offset reached RAM");

  AST_BANK0_GPR: assert property (@(posedge clock) disable iff (srst)
    (status_reg[6:5] == 2'b00 && dec_if.offset >= 7'h20)
    |-> dec_if.target == bmd_pkg::BMD_TGT_GPR && dec_if.ram_index == {2'b00, dec_if.offset})
    else $error("bank 0 RAM offset misdecoded");

  AST_STATUS_EVERY_BANK: assert property (@(posedge clock) disable iff (srst)
    dec_if.offset == 7'h03 |-> dec_if.target == bmd_pkg::BMD_TGT_STATUS)
    else $error("status not decoded in this bank");

  AST_STATUS_MIRROR_WRITE: assert property (@(posedge clock) disable iff (srst)
    (wr_fire && dec_if.offset == 7'h03 && status_reg[6:5] == 2'b10)
    |=> status_reg == $past(pwdata[7:0]))
    else $error("mirrored status write lost");

  AST_POINTER_READ: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && addr_ok && dec_if.offset == 7'h04) ##1 access_ph
    |-> prdata == {24'h000000, pointer_reg})
    else $error("pointer read wrong");

  AST_INDIRECT_REDIRECT: assert property (@(posedge clock) disable iff (srst)
    dec_if.offset == 7'h00 |-> dec_if.indirect && dec_if.file_addr[7:0] == pointer_reg)
    else $error("offset 00h not redirected");

  AST_COMMON_AREA: assert property (@(posedge clock) disable iff (srst)
    (status_reg[6:5] != 2'b00 && dec_if.offset >= 7'h70)
    |-> dec_if.ram_index == {2'b00, dec_if.offset})
    else $error("common area not aliased to bank 0");

  AST_HIGH_BANK_RAM: assert property (@(posedge clock) disable iff (srst)
    (status_reg[6] && dec_if.offset >= 7'h10 && dec_if.offset <= 7'h1F)
    |-> dec_if.target == bmd_pkg::BMD_TGT_GPR)
    else $error("upper bank offset 10h-1Fh not in RAM");

  AST_HIGH_BANK_SFR: assert property (@(posedge clock) disable iff (srst)
    (status_reg[6] && dec_if.offset >= 7'h05 && dec_if.offset <= 7'h0F)
    |-> dec_if.target == bmd_pkg::BMD_TGT_NONE)
    else $error("upper bank control offset reached RAM");

  AST_INDIRECT_UPPER: assert property (@(posedge clock) disable iff (srst)
    dec_if.indirect |-> dec_if.file_addr[8] == status_reg[bmd_pkg::IND_BANK_BIT])
    else $error("indirect upper bank bit wrong");

  AST_STATUS_HOLD: assert property (@(posedge clock) disable iff (srst)
    (!srst && !(wr_fire && dec_if.target == bmd_pkg::BMD_TGT_STATUS))
    |=> $stable(status_reg))
    else $error("status moved without a write");

  AST_POINTER_HOLD: assert property (@(posedge clock) disable iff (srst)
    (!srst && !(wr_fire && dec_if.target == bmd_pkg::BMD_TGT_POINTER))
    |=> $stable(pointer_reg))
    else $error("pointer moved without a write");

  AST_STATUS_READ: assert property (@(posedge clock) disable iff (srst)
    (setup_ph && !pwrite && addr_ok && dec_if.offset == 7'h03) ##1 access_ph
    |-> prdata == {24'h000000, status_reg})
    else $error("status read wrong");
endmodule : bmd_top

// ---- verif/bmd_core_model.sv ----
`timescale 1ns/1ns
module bmd_core_model (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end

  // One APB transfer; waits on pready, never assumes a latency
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Only the bench's cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look valid
    pwdata <= ~d;
  endtask : xfer
endmodule : bmd_core_model

// ---- verif/bmd_tb_top.sv ----
`timescale 1ns/1ns
module bmd_tb_top;
  typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d;} bmd_row_t;
  localparam int NR = 24;
  // Write rows give data, read rows the expected byte
  localparam bmd_row_t ROWS [NR] = '{
    '{1, 12'h00C, 8'h00}, '{1, 12'h080, 8'h11}, '{0, 12'h080, 8'h11},
    '{1, 12'h00C, 8'h20}, '{1, 12'h080, 8'h22}, '{0, 12'h080, 8'h22},
    '{1, 12'h00C, 8'h40}, '{1, 12'h080, 8'h66}, '{1, 12'h00C, 8'h00},
    '{0, 12'h080, 8'h11}, '{1, 12'h014, 8'h55}, '{0, 12'h014, 8'h00},
    '{1, 12'h1FC, 8'h33}, '{1, 12'h00C, 8'h60}, '{0, 12'h1FC, 8'h33},
    '{0, 12'h00C, 8'h60}, '{1, 12'h014, 8'h55}, '{0, 12'h014, 8'h00},
    '{1, 12'h010, 8'hA0}, '{0, 12'h000, 8'h22}, '{1, 12'h000, 8'h77},
    '{1, 12'h00C, 8'h20}, '{0, 12'h080, 8'h77}, '{0, 12'h010, 8'hA0}
  };
  logic clock, srst, psel, penable, pwrite, pready, pslverr, bank_sel_high, bank_sel_low;
  logic err;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [3:0] pstrb;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  bmd_core_model core (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  bmd_top dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bank_sel_high(bank_sel_high), .bank_sel_low(bank_sel_low));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Hang guard, well above the roughly one hundred cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    srst = 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk({30'h0, bank_sel_high, bank_sel_low}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    core.xfer(1'b0, 32'h0C, 32'h0, q, err);
    chk(q, 32'h0);
    chk({31'h0, err}, 32'h0);
    for (int i = 0; i < NR; i++) begin
      core.xfer(ROWS[i].wr, {20'h0, ROWS[i].a}, {24'h0, ROWS[i].d}, q, err);
      if (!ROWS[i].wr) chk(q, {24'h0, ROWS[i].d});
    end
    core.xfer(1'b1, 32'h0C, 32'h40, q, err);
    @(negedge clock);
    chk({30'h0, bank_sel_high, bank_sel_low}, 32'h2);
    // Bank 2 offset 10h is RAM, unlike the same offset in bank 0
    core.xfer(1'b1, 32'h40, 32'h5A, q, err);
    core.xfer(1'b0, 32'h40, 32'h0, q, err);
    chk(q, 32'h5A);
    core.xfer(1'b0, 32'h201, 32'h0, q, err);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    // Reset in mid-run must clear the bank select again
    @(posedge clock);
    srst <= 1'b1;
    @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    core.xfer(1'b0, 32'h0C, 32'h0, q, err);
    chk(q, 32'h0);
    // Pointer held A0h before the reset
    core.xfer(1'b0, 32'h10, 32'h0, q, err);
    chk(q, 32'h0);
    summarize();
  end
endmodule : bmd_tb_top
